// ### hdl/flag_bus_if.sv
// flag bundle carried from the comparison unit to the top
// assumes one clock domain; producer drives, consumer reads
`timescale 1ns/10ps
interface flag_bus_if;
  logic done;
  logic match;
  logic running;
  logic ready;
  modport producer (output done, match, running, ready);
  modport consumer (input done, match, running, ready);
endinterface

// ### hdl/servo_status_output_select.sv
// top of the status output block: apb settings, slot routing, active-low outputs
// assumes apb master on the same clock; torque-limit and brake flags come from outside
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/10ps

// Behaviour
// RULE1: in position mode, done flag set when absolute error within range
// RULE2: completion range accepts 0..500, resets to 10
// RULE3: position error counted in geared reference units, not encoder counts
// RULE4: torque mode holds done flag asserted
// RULE5: speed mode routes speed match onto the done function
// RULE6: match flag set when absolute speed difference at most width
// RULE7: match width in r/min accepts 0..100, resets to 10
// RULE8: torque mode holds match flag asserted
// RULE9: running flag set while speed exceeds zero-speed level
// RULE10: zero-speed level in r/min accepts 0..2500, resets to 20
// RULE11: ready flag only with main power on and no alarm
// RULE12: outputs drive low when active, high when inactive
// RULE13: three slot selectors accept 0..4, reset to 0, 1, 2
// RULE14: selector 0 done/match, 1 running, 2 ready, 3 torque limit, 4 brake
// RULE15: host waits for done flag before dependent actions
// RULE16: flags re-evaluated each cycle, slot outputs registered
module servo_status_output_select
#(
  parameter int P_W = status_out_pkg::POS_W,
  parameter int S_W = status_out_pkg::SPEED_W
) (
  input  wire logic                                 CLOCK,
  input  wire logic                                 RST,
  input  wire logic                                 PSEL,
  input  wire logic                                 PENABLE,
  input  wire logic                                 PWRITE,
  input  wire logic [status_out_pkg::ADDR_W-1:0]    PADDR,
  input  wire logic [status_out_pkg::DATA_W-1:0]    PWDATA,
  output logic      [status_out_pkg::DATA_W-1:0]    PRDATA,
  output logic                                      PREADY,
  output logic                                      PSLVERR,
  input  wire logic signed [P_W-1:0]                POSITION_ERROR,
  input  wire logic signed [S_W-1:0]                SPEED_REFERENCE,
  input  wire logic signed [S_W-1:0]                SPEED_ACTUAL,
  input  wire logic                                 MAIN_POWER_ON,
  input  wire logic                                 ALARM_ACTIVE,
  input  wire logic                                 TORQUE_LIMITED_FLAG,
  input  wire logic                                 BRAKE_INTERLOCK_FLAG,
  output logic      [status_out_pkg::NUM_SLOTS-1:0] SLOT_OUT_N
);
  import status_out_pkg::*;

  flag_bus_if flags ();

  logic [RANGE_W-1:0] position_done_range_reg,   position_done_range_next;
  logic [WIDTH_W-1:0] speed_match_width_reg,     speed_match_width_next;
  logic [LEVEL_W-1:0] zero_speed_level_reg,      zero_speed_level_next;
  logic [SEL_W-1:0]   slot_a_function_select_reg, slot_a_function_select_next;
  logic [SEL_W-1:0]   slot_b_function_select_reg, slot_b_function_select_next;
  logic [SEL_W-1:0]   slot_c_function_select_reg, slot_c_function_select_next;
  control_mode_t      mode_reg,                  mode_next;
  logic [DATA_W-1:0]  prdata_reg,                prdata_next;
  logic               pready_reg,                pready_next;
  logic               pslverr_reg,               pslverr_next;
  logic [NUM_SLOTS-1:0] slot_n_reg,              slot_n_next;
  logic [SEL_W-1:0]   sel_vec [NUM_SLOTS];
  logic               positioning_done_flag;
  logic               speed_match_flag;
  logic               motor_running_flag;
  logic               servo_ready_flag;
  logic               done_or_match;
  logic               access;
  logic               wr_ok;

  status_flag_compare #(
    .P_W (P_W),
    .S_W (S_W)
  ) u_compare (
    .clk           (CLOCK),
    .rst           (RST),
    .mode          (mode_reg),
    .pos_error     (POSITION_ERROR),
    .speed_ref     (SPEED_REFERENCE),
    .speed_act     (SPEED_ACTUAL),
    .done_range    (position_done_range_reg),
    .match_width   (speed_match_width_reg),
    .zero_level    (zero_speed_level_reg),
    .main_power_on (MAIN_POWER_ON),
    .alarm_active  (ALARM_ACTIVE),
    .flags         (flags.producer)
  );

  assign positioning_done_flag = flags.done;
  assign speed_match_flag      = flags.match;
  assign motor_running_flag    = flags.running;
  assign servo_ready_flag      = flags.ready;

  // apb slave, one wait state
  always_comb begin
    access                       = PSEL && PENABLE && !pready_reg;
    position_done_range_next     = position_done_range_reg;
    speed_match_width_next       = speed_match_width_reg;
    zero_speed_level_next        = zero_speed_level_reg;
    slot_a_function_select_next  = slot_a_function_select_reg;
    slot_b_function_select_next  = slot_b_function_select_reg;
    slot_c_function_select_next  = slot_c_function_select_reg;
    mode_next                    = mode_reg;
    prdata_next                  = prdata_reg;
    pready_next                  = access;
    pslverr_next                 = 1'b0;
    wr_ok                        = 1'b0;
    if (access && PWRITE) begin
      case (PADDR)
        OFS_DONE_RANGE: begin
          wr_ok = (PWDATA <= DATA_W'(DONE_RANGE_MAX)); // [RULE2]
          if (wr_ok) position_done_range_next = PWDATA[RANGE_W-1:0];
        end
        OFS_MATCH_WIDTH: begin
          wr_ok = (PWDATA <= DATA_W'(MATCH_WIDTH_MAX)); // [RULE7]
          if (wr_ok) speed_match_width_next = PWDATA[WIDTH_W-1:0];
        end
        OFS_ZERO_LEVEL: begin
          wr_ok = (PWDATA <= DATA_W'(ZERO_LEVEL_MAX)); // [RULE10]
          if (wr_ok) zero_speed_level_next = PWDATA[LEVEL_W-1:0];
        end
        OFS_SLOT_SELECT: begin
          // each selector limited to 0..4 [RULE13]
          wr_ok = (PWDATA[SEL_A_LSB +: SEL_W] <= SEL_MAX) && (PWDATA[SEL_B_LSB +: SEL_W] <= SEL_MAX)
               && (PWDATA[SEL_C_LSB +: SEL_W] <= SEL_MAX);
          if (wr_ok) begin
            slot_a_function_select_next = PWDATA[SEL_A_LSB +: SEL_W];
            slot_b_function_select_next = PWDATA[SEL_B_LSB +: SEL_W];
            slot_c_function_select_next = PWDATA[SEL_C_LSB +: SEL_W];
          end
        end
        OFS_CONTROL_MODE: begin
          wr_ok = (PWDATA[1:0] != 2'b11) && (PWDATA[DATA_W-1:2] == '0);
          if (wr_ok) mode_next = control_mode_t'(PWDATA[1:0]);
        end
        default: wr_ok = 1'b0;
      endcase
      pslverr_next = !wr_ok;
    end else if (access) begin
      prdata_next = '0;
      case (PADDR)
        OFS_DONE_RANGE:   prdata_next = DATA_W'(position_done_range_reg);
        OFS_MATCH_WIDTH:  prdata_next = DATA_W'(speed_match_width_reg);
        OFS_ZERO_LEVEL:   prdata_next = DATA_W'(zero_speed_level_reg);
        OFS_SLOT_SELECT: begin
          prdata_next[SEL_A_LSB +: SEL_W] = slot_a_function_select_reg;
          prdata_next[SEL_B_LSB +: SEL_W] = slot_b_function_select_reg;
          prdata_next[SEL_C_LSB +: SEL_W] = slot_c_function_select_reg;
        end
        OFS_CONTROL_MODE: prdata_next = DATA_W'(mode_reg);
        OFS_STATUS: begin
          prdata_next[ST_DONE]    = positioning_done_flag;
          prdata_next[ST_MATCH]   = speed_match_flag;
          prdata_next[ST_RUNNING] = motor_running_flag;
          prdata_next[ST_READY]   = servo_ready_flag;
          prdata_next[ST_SLOT +: NUM_SLOTS] = ~slot_n_reg;
        end
        default:          pslverr_next = 1'b1;
      endcase
    end
  end

  // slot routing, one selector per slot
  always_comb begin
    // speed mode swaps in the match flag [RULE5]
    done_or_match = (mode_reg == MODE_SPEED) ? speed_match_flag : positioning_done_flag;
    sel_vec[0]    = slot_a_function_select_reg;
    sel_vec[1]    = slot_b_function_select_reg;
    sel_vec[2]    = slot_c_function_select_reg;
  end

  generate
    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
      always_comb begin
        case (slot_function_t'(sel_vec[i])) // [RULE14]
          FUNC_DONE_OR_MATCH: slot_n_next[i] = !done_or_match; // [RULE12]
          FUNC_RUNNING:       slot_n_next[i] = !motor_running_flag;
          FUNC_READY:         slot_n_next[i] = !servo_ready_flag;
          FUNC_TORQUE_LIMIT:  slot_n_next[i] = !TORQUE_LIMITED_FLAG;
          FUNC_BRAKE:         slot_n_next[i] = !BRAKE_INTERLOCK_FLAG;
          default:            slot_n_next[i] = 1'b1;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      position_done_range_reg    <= DONE_RANGE_RST;
      speed_match_width_reg      <= MATCH_WIDTH_RST;
      zero_speed_level_reg       <= ZERO_LEVEL_RST;
      slot_a_function_select_reg <= SEL_A_RST;
      slot_b_function_select_reg <= SEL_B_RST;
      slot_c_function_select_reg <= SEL_C_RST;
      mode_reg                   <= MODE_POSITION;
      prdata_reg                 <= '0;
      pready_reg                 <= 1'b0;
      pslverr_reg                <= 1'b0;
      slot_n_reg                 <= '1;
    end else begin
      position_done_range_reg    <= position_done_range_next;
      speed_match_width_reg      <= speed_match_width_next;
      zero_speed_level_reg       <= zero_speed_level_next;
      slot_a_function_select_reg <= slot_a_function_select_next;
      slot_b_function_select_reg <= slot_b_function_select_next;
      slot_c_function_select_reg <= slot_c_function_select_next;
      mode_reg                   <= mode_next;
      prdata_reg                 <= prdata_next;
      pready_reg                 <= pready_next;
      pslverr_reg                <= pslverr_next;
      slot_n_reg                 <= slot_n_next; // [RULE16]
    end
  end

  assign PRDATA     = prdata_reg;
  assign PREADY     = pready_reg;
  assign PSLVERR    = pslverr_reg;
  assign SLOT_OUT_N = slot_n_reg;
endmodule

// ### hdl/status_flag_compare.sv
// comparison unit producing the four status flags every cycle
// assumes settings and feedback are synchronous to the clock
`timescale 1ns/10ps
module status_flag_compare
  import status_out_pkg::*;
#(
  parameter int P_W = POS_W,
  parameter int S_W = SPEED_W
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire control_mode_t        mode,
  input  wire logic signed [P_W-1:0] pos_error,
  input  wire logic signed [S_W-1:0] speed_ref,
  input  wire logic signed [S_W-1:0] speed_act,
  input  wire logic [RANGE_W-1:0]   done_range,
  input  wire logic [WIDTH_W-1:0]   match_width,
  input  wire logic [LEVEL_W-1:0]   zero_level,
  input  wire logic                 main_power_on,
  input  wire logic                 alarm_active,
  flag_bus_if.producer              flags
);
  logic [P_W-1:0] pos_abs;
  logic [S_W:0]   diff_abs;
  logic [S_W:0]   diff_raw;
  logic [S_W-1:0] speed_abs;
  logic           done_reg,    done_next;
  logic           match_reg,   match_next;
  logic           running_reg, running_next;
  logic           ready_reg,   ready_next;

  always_comb begin
    pos_abs   = pos_error[P_W-1] ? P_W'(-pos_error) : pos_error;
    diff_raw  = {speed_ref[S_W-1], speed_ref} - {speed_act[S_W-1], speed_act};
    diff_abs  = diff_raw[S_W] ? (S_W+1)'(-diff_raw) : diff_raw;
    speed_abs = speed_act[S_W-1] ? S_W'(-speed_act) : speed_act;
    // error in reference units, compared against range [RULE1] [RULE3]
    done_next    = (pos_abs <= P_W'(done_range));
    match_next   = (diff_abs <= (S_W+1)'(match_width)); // [RULE6]
    running_next = (speed_abs > S_W'(zero_level)); // [RULE9]
    ready_next   = main_power_on && !alarm_active; // [RULE11]
    if (mode == MODE_TORQUE) begin
      done_next  = 1'b1; // [RULE4]
      match_next = 1'b1; // [RULE8]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg    <= 1'b0;
      match_reg   <= 1'b0;
      running_reg <= 1'b0;
      ready_reg   <= 1'b0;
    end else begin
      done_reg    <= done_next; // [RULE16]
      match_reg   <= match_next;
      running_reg <= running_next;
      ready_reg   <= ready_next;
    end
  end

  assign flags.done    = done_reg;
  assign flags.match   = match_reg;
  assign flags.running = running_reg;
  assign flags.ready   = ready_reg;
endmodule

// ### hdl/status_out_pkg.sv
// status output block: shared register map, field layouts, reset values
// assumes a 32-bit apb slave and a 100 mhz core clock
package status_out_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_DONE_RANGE   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_MATCH_WIDTH  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_ZERO_LEVEL   = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_SLOT_SELECT  = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_MODE = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_STATUS       = 12'h014;

  // setting widths, limits and reset values
  localparam int RANGE_W = 9;
  localparam int WIDTH_W = 7;
  localparam int LEVEL_W = 12;
  localparam int SEL_W   = 3;
  localparam int SPEED_W = 16;
  localparam int POS_W   = 32;

  localparam logic [RANGE_W-1:0] DONE_RANGE_MAX  = 9'h1f4;
  localparam logic [RANGE_W-1:0] DONE_RANGE_RST  = 9'h00a;
  localparam logic [WIDTH_W-1:0] MATCH_WIDTH_MAX = 7'h64;
  localparam logic [WIDTH_W-1:0] MATCH_WIDTH_RST = 7'h0a;
  localparam logic [LEVEL_W-1:0] ZERO_LEVEL_MAX  = 12'h9c4;
  localparam logic [LEVEL_W-1:0] ZERO_LEVEL_RST  = 12'h014;
  localparam logic [SEL_W-1:0]   SEL_MAX         = 3'h4;
  localparam logic [SEL_W-1:0]   SEL_A_RST       = 3'h0;
  localparam logic [SEL_W-1:0]   SEL_B_RST       = 3'h1;
  localparam logic [SEL_W-1:0]   SEL_C_RST       = 3'h2;

  // slot select field positions
  localparam int SEL_A_LSB = 0;
  localparam int SEL_B_LSB = 4;
  localparam int SEL_C_LSB = 8;

  localparam int NUM_SLOTS = 3;

  typedef enum logic [1:0] {
    MODE_POSITION = 2'b00,
    MODE_SPEED    = 2'b01,
    MODE_TORQUE   = 2'b10
  } control_mode_t;

  typedef enum logic [2:0] {
    FUNC_DONE_OR_MATCH = 3'b000,
    FUNC_RUNNING       = 3'b001,
    FUNC_READY         = 3'b010,
    FUNC_TORQUE_LIMIT  = 3'b011,
    FUNC_BRAKE         = 3'b100
  } slot_function_t;

  // status bit positions
  localparam int ST_DONE    = 0;
  localparam int ST_MATCH   = 1;
  localparam int ST_RUNNING = 2;
  localparam int ST_READY   = 3;
  localparam int ST_SLOT    = 4;

endpackage

// ### tb/host_model.sv
// host controller reading slot a as its positioning interlock
// assumes slot a carries the done function, active low
`timescale 1ns/10ps
module host_model (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic [2:0] SLOT_OUT_N,
  output logic            step_ok
);
  // next move allowed only once done is shown
  always_ff @(posedge CLOCK) begin
    step_ok <= !RST && !SLOT_OUT_N[0];
  end
endmodule

// ### tb/status_out_monitor.sv
// checker for the status output block, watching top ports only
// assumes binding onto servo_status_output_select
`timescale 1ns/10ps
module status_out_monitor (
  input wire logic                              CLOCK,
  input wire logic                              RST,
  input wire logic                              PSEL,
  input wire logic                              PENABLE,
  input wire logic                              PWRITE,
  input wire logic [status_out_pkg::ADDR_W-1:0] PADDR,
  input wire logic [status_out_pkg::DATA_W-1:0] PWDATA,
  input wire logic                              PREADY,
  input wire logic                              PSLVERR,
  input wire logic                              MAIN_POWER_ON,
  input wire logic                              ALARM_ACTIVE,
  input wire logic                              TORQUE_LIMITED_FLAG,
  input wire logic                              BRAKE_INTERLOCK_FLAG,
  input wire logic [status_out_pkg::NUM_SLOTS-1:0] SLOT_OUT_N
);
  import status_out_pkg::*;
  logic [10:0] sel_q, sel_d;
  logic [1:0]  mode_q, mode_d, up;
  logic [3:0]  ins, inq;
  logic [2:0]  rtv;
  logic        wr_ok, quiet, acc;
  function automatic logic act_n(input logic [2:0] s, input logic [3:0] v);
    case (s)
      3'h2: return !(v[3] && !v[2]);
      3'h3: return !v[1];
      default: return !v[0];
    endcase
  endfunction
  assign ins = {MAIN_POWER_ON, ALARM_ACTIVE, TORQUE_LIMITED_FLAG, BRAKE_INTERLOCK_FLAG};
  assign acc = PSEL && PENABLE && PREADY && PWRITE;
  assign wr_ok = acc && !PSLVERR;
  // no write completing now: inputs, selector and mode copies unchanged since the previous edge
  assign quiet = inq == ins && sel_q == sel_d && mode_q == mode_d && up == 2'h3 && !acc;
  assign rtv = {act_n(sel_q[10:8], ins), act_n(sel_q[6:4], ins), act_n(sel_q[2:0], ins)};
  always_ff @(posedge CLOCK) begin
    inq <= ins;
    sel_d <= sel_q;
    mode_d <= mode_q;
    if (RST) begin
      sel_q <= 11'h210;
      mode_q <= 2'h0;
      up <= 2'h0;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (wr_ok && PADDR == OFS_SLOT_SELECT) sel_q <= PWDATA[10:0];
      if (wr_ok && PADDR == OFS_CONTROL_MODE) mode_q <= PWDATA[1:0];
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_ready_one_cycle: assert property (PREADY |=> !PREADY) else $error("pready held");
  a_access_answer: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("no answer");
  a_idle_no_ready: assert property (!PSEL |=> !PREADY) else $error("pready while idle");
  a_reset_outputs: assert property (disable iff (1'b0) RST |=> SLOT_OUT_N == 3'h7 && !PREADY)
    else $error("bad reset outputs");
  a_limit_refuse: assert property (acc && (
    (PADDR == OFS_DONE_RANGE && PWDATA > 32'(DONE_RANGE_MAX))
    || (PADDR == OFS_MATCH_WIDTH && PWDATA > 32'(MATCH_WIDTH_MAX))
    || (PADDR == OFS_ZERO_LEVEL && PWDATA > 32'(ZERO_LEVEL_MAX))
    || (PADDR == OFS_SLOT_SELECT && PWDATA[2:0] > SEL_MAX)) |-> PSLVERR) else $error("limit not refused");
  a_route_slot_a: assert property (quiet && sel_q[2:0] inside {3'h2, 3'h3, 3'h4} |=>
    SLOT_OUT_N[0] == $past(rtv[0])) else $error("slot a route");
  a_route_slot_b: assert property (quiet && sel_q[6:4] inside {3'h2, 3'h3, 3'h4} |=>
    SLOT_OUT_N[1] == $past(rtv[1])) else $error("slot b route");
  a_route_slot_c: assert property (quiet && sel_q[10:8] inside {3'h2, 3'h3, 3'h4} |=>
    SLOT_OUT_N[2] == $past(rtv[2])) else $error("slot c route");
  a_torque_done: assert property (quiet && mode_q == 2'h2 && sel_q[2:0] == 3'h0 |=> !SLOT_OUT_N[0])
    else $error("torque mode done off");
  c_refused: cover property (acc && PSLVERR);
  c_torque: cover property (quiet && mode_q == 2'h2 && sel_q[2:0] == 3'h0);
  c_brake: cover property (quiet && sel_q[10:8] == 3'h4);
endmodule
bind servo_status_output_select status_out_monitor mon (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .MAIN_POWER_ON(MAIN_POWER_ON), .ALARM_ACTIVE(ALARM_ACTIVE), .TORQUE_LIMITED_FLAG(TORQUE_LIMITED_FLAG),
  .BRAKE_INTERLOCK_FLAG(BRAKE_INTERLOCK_FLAG), .SLOT_OUT_N(SLOT_OUT_N));

// ### tb/test_servo_status_output_select.sv
// self-checking bench for the status output block
// assumes the monitor is bound and the host model watches the slots
`timescale 1ns/10ps
module test_servo_status_output_select;
  import status_out_pkg::*;
  logic               CLOCK, RST, PSEL, PENABLE, PWRITE, pw, al, tq, bk, step_ok;
  logic        [11:0] PADDR;
  logic        [31:0] PWDATA, PRDATA, seed;
  logic               PREADY, PSLVERR;
  logic signed [31:0] POSITION_ERROR;
  logic signed [15:0] SREF, SACT;
  logic        [2:0]  SLOT_OUT_N;
  int                 dr, mw, zl, md, pe, sr, sa, fail_count, checks_done;
  int                 sel [3];
  servo_status_output_select dut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .POSITION_ERROR(POSITION_ERROR), .SPEED_REFERENCE(SREF), .SPEED_ACTUAL(SACT), .MAIN_POWER_ON(pw),
    .ALARM_ACTIVE(al), .TORQUE_LIMITED_FLAG(tq), .BRAKE_INTERLOCK_FLAG(bk), .SLOT_OUT_N(SLOT_OUT_N));
  host_model host (.CLOCK(CLOCK), .RST(RST), .SLOT_OUT_N(SLOT_OUT_N), .step_ok(step_ok));
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] flg();
    logic d, m, r;
    d = (pe < 0 ? -pe : pe) <= dr;
    m = (sr > sa ? sr - sa : sa - sr) <= mw;
    r = (sa < 0 ? -sa : sa) > zl;
    if (md == 2) begin
      d = 1'b1;
      m = 1'b1;
    end
    return {pw && !al, r, m, d};
  endfunction
  function automatic logic [2:0] slots();
    logic [3:0] f;
    logic [4:0] on;
    logic [2:0] r;
    f = flg();
    on = {bk, tq, f[3], f[2], md == 1 ? f[1] : f[0]};
    for (int i = 0; i < 3; i++) r[i] = !on[sel[i]];
    return r;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee,
                     input logic [31:0] x, input logic [31:0] mk);
    int          n;
    logic [31:0] r;
    logic        e;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    chk("pready", n < 20, 1);
    chk("pslverr", e, ee);
    if (!w && !ee) chk("prdata", r & mk, x & mk);
  endtask
  task automatic cfg();
    dr = int'(xs() % 501);
    mw = int'(xs() % 101);
    zl = int'(xs() % 41);
    foreach (sel[i]) sel[i] = int'(xs() % 5);
    apb(1, OFS_DONE_RANGE, dr, 0, 0, 0);
    apb(1, OFS_MATCH_WIDTH, mw, 0, 0, 0);
    apb(1, OFS_ZERO_LEVEL, zl, 0, 0, 0);
    apb(1, OFS_SLOT_SELECT, sel[2] * 256 + sel[1] * 16 + sel[0], 0, 0, 0);
  endtask
  task automatic run_one();
    logic [31:0] r;
    logic [2:0]  s;
    @(posedge CLOCK);
    pe = int'(xs() % (2 * dr + 9)) - dr - 4;
    sr = int'(xs() % 101) - 50;
    sa = sr + int'(xs() % (2 * mw + 9)) - mw - 4;
    r = xs();
    POSITION_ERROR <= pe;
    SREF <= 16'(sr);
    SACT <= 16'(sa);
    {pw, al, tq, bk} <= r[3:0];
    repeat (3) @(posedge CLOCK);
    s = slots();
    chk("slots", SLOT_OUT_N, s);
    apb(0, OFS_STATUS, 0, 0, {25'h0, ~s, flg()}, '1);
    if (md == 0 && sel[0] == 0) chk("host", step_ok, !s[0]);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200us;
    fail_count++;
    close_out();
  end
  initial begin
    {RST, PSEL, PENABLE, PWRITE, pw, al, tq, bk} = 8'h80;
    {PADDR, PWDATA, POSITION_ERROR, SREF, SACT} = '0;
    {seed, dr, mw, zl, md, pe, sr, sa, fail_count, checks_done} = {32'd25, 32'd10, 32'd10, 32'd20, 192'd0};
    sel = '{0, 1, 2};
    repeat (3) @(posedge CLOCK);
    chk("reset slots", SLOT_OUT_N, 3'h7);
    RST <= 1'b0;
    apb(0, OFS_DONE_RANGE, 0, 0, 10, '1);
    apb(0, OFS_MATCH_WIDTH, 0, 0, 10, '1);
    apb(0, OFS_ZERO_LEVEL, 0, 0, 20, '1);
    apb(0, OFS_SLOT_SELECT, 0, 0, 32'h210, '1);
    $display("test reset values done");
    apb(1, OFS_DONE_RANGE, 501, 1, 0, 0);
    apb(1, OFS_DONE_RANGE, 500, 0, 0, 0);
    apb(0, OFS_DONE_RANGE, 0, 0, 500, '1);
    apb(1, OFS_MATCH_WIDTH, 101, 1, 0, 0);
    apb(1, OFS_ZERO_LEVEL, 2501, 1, 0, 0);
    apb(1, OFS_ZERO_LEVEL, 2500, 0, 0, 0);
    apb(0, OFS_ZERO_LEVEL, 0, 0, 2500, '1);
    apb(1, OFS_SLOT_SELECT, 32'h215, 1, 0, 0);
    apb(1, OFS_CONTROL_MODE, 3, 1, 0, 0);
    apb(1, OFS_STATUS, 0, 1, 0, 0);
    apb(0, 12'h020, 0, 1, 0, 0);
    apb(0, OFS_SLOT_SELECT, 0, 0, 32'h210, '1);
    dr = 500;
    zl = 2500;
    $display("test limits done");
    for (int m = 0; m < 3; m++) begin
      md = m;
      apb(1, OFS_CONTROL_MODE, md, 0, 0, 0);
      for (int k = 0; k < 24; k++) begin
        if (k % 6 == 0) cfg();
        run_one();
      end
      $display("test mode %0d done", m);
    end
    for (int c = 0; c < 5; c++) begin
      sel = '{c, c, c};
      apb(1, OFS_SLOT_SELECT, c * 273, 0, 0, 0);
      run_one();
      run_one();
    end
    $display("test selector codes done");
    close_out();
  end
endmodule
